// ==== hdl/igf_change_detect.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "igf_consts.svh"
module igf_change_detect
    import igf_pkg::*;
(
    input  wire logic       clk_i,      // System clock
    input  wire logic       resetn_i,   // Sync reset, active low
    input  wire logic [3:0] pins_i,     // Upper nibble of the port
    input  wire logic       read_i,     // Port read strobe
    output logic            mismatch_o  // Pins differ from last read
);
    logic [3:0] latch_q;
    logic [1:0] wait_q;

    // The latched copy is refreshed on the read and again one instruction cycle after it
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            wait_q <= 2'h0;
        else if (read_i)
            wait_q <= `IGF_INSTR_CYCLES;
        else if (wait_q != 2'h0)
            wait_q <= wait_q - 2'h1;
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            latch_q <= 4'h0;
        else if (read_i || wait_q != 2'h0)
            latch_q <= pins_i;
    end

    assign mismatch_o = (latch_q != pins_i);

    AST_MISMATCH_ENDS: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (read_i && $stable(pins_i)) ##1 $stable(pins_i) |=> !mismatch_o)
        else $error("mismatch persists after port read");
endmodule
`default_nettype wire

// ==== hdl/igf_top.sv ====
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "igf_consts.svh"
module igf_top
    import igf_pkg::*;
(
    input  wire logic        clk_i,           // 50 MHz clock
    input  wire logic        resetn_i,        // Sync reset, active low
    input  wire logic [31:0] s_axi_awaddr,    // Write address
    input  wire logic        s_axi_awvalid,   // Write address valid
    output logic             s_axi_awready,   // Write address ready
    input  wire logic [31:0] s_axi_wdata,     // Write data
    input  wire logic [3:0]  s_axi_wstrb,     // Write strobes
    input  wire logic        s_axi_wvalid,    // Write data valid
    output logic             s_axi_wready,    // Write data ready
    output logic [1:0]       s_axi_bresp,     // Write response
    output logic             s_axi_bvalid,    // Write response valid
    input  wire logic        s_axi_bready,    // Write response ready
    input  wire logic [31:0] s_axi_araddr,    // Read address
    input  wire logic        s_axi_arvalid,   // Read address valid
    output logic             s_axi_arready,   // Read address ready
    output logic [31:0]      s_axi_rdata,     // Read data
    output logic [1:0]       s_axi_rresp,     // Read response
    output logic             s_axi_rvalid,    // Read data valid
    input  wire logic        s_axi_rready,    // Read data ready
    input  wire logic        timer_zero_ovf_i, // Timer 0 overflow pulse
    input  wire logic        ext_pin_zero_i,   // External pin 0 event pulse
    input  wire logic [3:0]  second_io_port_i, // Port B pins 7..4
    input  wire logic        port_read_i,      // Port B read strobe
    output logic             irq_high_o,       // Request, high priority
    output logic             irq_low_o         // Request, low priority
);
    ////////////////////////////////////////////////////////////////////
    function automatic logic addr_is(input logic [31:0] a, input logic [31:0] off);
        addr_is = (a[7:2] == off[7:2]) && (a[31:8] == 24'h00_0000);
    endfunction

    localparam igf_reg_t RST_GF = `IGF_RST_GATEFLAGS;
    igf_reg_t   gate_q;
    logic [4:0] ctl_q;
    logic [2:0] flg_q;
    // Gates and enables are kept apart from the flags so each has one writer
    assign gate_q = {ctl_q, flg_q};
    logic [3:0] prio_q;
    logic       mismatch;
    igf_wr_e    wst_q;
    igf_rd_e    rst_q;
    logic       aw_hold_q;
    logic       w_hold_q;
    logic [31:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;

    igf_change_detect u_chg (
        .clk_i      (clk_i),
        .resetn_i   (resetn_i),
        .pins_i     (second_io_port_i),
        .read_i     (port_read_i),
        .mismatch_o (mismatch)
    );

    ////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order
    logic aw_take;
    logic w_take;
    logic wr_go;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take  = s_axi_wvalid && s_axi_wready;
    assign wr_go   = (wst_q == IGF_WR_IDLE) && (aw_hold_q || aw_take)
                     && (w_hold_q || w_take);

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            aw_hold_q <= 1'b0;
            awaddr_q  <= 32'h0000_0000;
        end
        else if (wr_go)
            aw_hold_q <= 1'b0;
        else if (aw_take)
        begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            w_hold_q <= 1'b0;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
        end
        else if (wr_go)
            w_hold_q <= 1'b0;
        else if (w_take)
        begin
            w_hold_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
        end
    end

    assign s_axi_awready = !aw_hold_q && (wst_q == IGF_WR_IDLE);
    assign s_axi_wready  = !w_hold_q && (wst_q == IGF_WR_IDLE);

    logic [31:0] wa;
    logic [31:0] wd;
    logic        wb0;
    assign wa  = aw_hold_q ? awaddr_q : s_axi_awaddr;
    assign wd  = w_hold_q ? wdata_q : s_axi_wdata;
    assign wb0 = w_hold_q ? wstrb_q[0] : s_axi_wstrb[0];

    logic wr_gate;
    logic wr_prio;
    logic wr_ok;
    assign wr_gate = wr_go && wb0 && addr_is(wa, `IGF_OFF_GATEFLAGS);
    assign wr_prio = wr_go && wb0 && addr_is(wa, `IGF_OFF_PRIOCTL);
    assign wr_ok   = addr_is(wa, `IGF_OFF_GATEFLAGS) || addr_is(wa, `IGF_OFF_PRIOCTL)
                     || addr_is(wa, `IGF_OFF_STATUS);

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            wst_q        <= IGF_WR_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `IGF_RESP_OKAY;
        end
        else unique case (wst_q)
            IGF_WR_IDLE:
                if (wr_go)
                begin
                    wst_q        <= IGF_WR_RESP;
                    s_axi_bvalid <= 1'b1;
                    s_axi_bresp  <= wr_ok ? `IGF_RESP_OKAY : `IGF_RESP_SLVERR;
                end
            IGF_WR_RESP:
                if (s_axi_bready)
                begin
                    wst_q        <= IGF_WR_IDLE;
                    s_axi_bvalid <= 1'b0;
                end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Read channel: one cycle from address to data
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            rst_q        <= IGF_RD_IDLE;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `IGF_RESP_OKAY;
        end
        else unique case (rst_q)
            IGF_RD_IDLE:
                if (s_axi_arvalid)
                begin
                    rst_q        <= IGF_RD_RESP;
                    s_axi_rvalid <= 1'b1;
                    s_axi_rresp  <= `IGF_RESP_OKAY;
                    if (addr_is(s_axi_araddr, `IGF_OFF_GATEFLAGS))
                        s_axi_rdata <= {24'h00_0000, gate_q};
                    else if (addr_is(s_axi_araddr, `IGF_OFF_PRIOCTL))
                        s_axi_rdata <= {28'h000_0000, prio_q};
                    else if (addr_is(s_axi_araddr, `IGF_OFF_STATUS))
                        s_axi_rdata <= {29'h0, mismatch, irq_low_o, irq_high_o};
                    else
                    begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `IGF_RESP_SLVERR;
                    end
                end
            IGF_RD_RESP:
                if (s_axi_rready)
                begin
                    rst_q        <= IGF_RD_IDLE;
                    s_axi_rvalid <= 1'b0;
                end
        endcase
    end
    assign s_axi_arready = (rst_q == IGF_RD_IDLE);

    ////////////////////////////////////////////////////////////////////
    // Gate and enable bits, written by software only
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            ctl_q <= RST_GF[7:3];
        else if (wr_gate)
            ctl_q <= wd[7:3];
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            prio_q <= `IGF_RST_PRIOCTL;
        else if (wr_prio)
            prio_q <= wd[3:0];
    end

    // Sticky flags: a source event wins over a software clear in the same cycle
    logic [2:0] src;
    assign src = {timer_zero_ovf_i, ext_pin_zero_i, mismatch};

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            flg_q <= RST_GF[2:0];
        else
            flg_q <= src | (wr_gate ? wd[2:0] & flg_q : flg_q);
    end

    ////////////////////////////////////////////////////////////////////
    // Request generation
    logic       prio_on;
    logic [2:0] pend;
    logic [2:0] is_hi;
    logic       ghg;
    logic       plg;
    logic       req_hi_d;
    logic       req_lo_d;
    assign prio_on = prio_q[`IGF_BIT_PRIO_ON];
    assign ghg     = gate_q[`IGF_BIT_GHG];
    assign plg     = gate_q[`IGF_BIT_PLG];
    assign is_hi   = {prio_q[`IGF_BIT_T0_HI], prio_q[`IGF_BIT_E0_HI], prio_q[`IGF_BIT_PB_HI]};
    // Enable masks each flag
    assign pend    = gate_q[5:3] & gate_q[2:0];

    // Core sources here are not peripherals, so bit six does not gate them
    // without priority; peripheral requests live elsewhere.
    always_comb
    begin
        if (!prio_on)
        begin
            req_hi_d = ghg && (pend != 3'h0);
            req_lo_d = 1'b0;
        end
        else
        begin
            req_hi_d = ghg && ((pend & is_hi) != 3'h0);
            req_lo_d = ghg && plg && ((pend & ~is_hi) != 3'h0);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            irq_high_o <= 1'b0;
            irq_low_o  <= 1'b0;
        end
        else
        begin
            irq_high_o <= req_hi_d;
            irq_low_o  <= req_lo_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    AST_FLAG_SETS: assert property (@(posedge clk_i) disable iff (!resetn_i)
        timer_zero_ovf_i |=> gate_q[`IGF_BIT_T0F])
        else $error("timer flag not set on overflow");
    AST_FLAG_STICKY: assert property (@(posedge clk_i) disable iff (!resetn_i)
        gate_q[`IGF_BIT_E0F] && !wr_gate |=> gate_q[`IGF_BIT_E0F])
        else $error("external flag dropped without clear");
    AST_CLEAR_WORKS: assert property (@(posedge clk_i) disable iff (!resetn_i)
        wr_gate && !wd[`IGF_BIT_T0F] && !timer_zero_ovf_i |=> !gate_q[`IGF_BIT_T0F])
        else $error("timer flag not cleared");
    AST_PB_SET: assert property (@(posedge clk_i) disable iff (!resetn_i)
        mismatch |=> gate_q[`IGF_BIT_PBF])
        else $error("port change flag missing");
    AST_NO_GLOBAL: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !ghg |=> !irq_high_o && !irq_low_o)
        else $error("request with global gate clear");
    AST_MASKED: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (pend == 3'h0) |=> !irq_high_o && !irq_low_o)
        else $error("request with no enabled flag");
    AST_LOW_NEEDS_BOTH: assert property (@(posedge clk_i) disable iff (!resetn_i)
        irq_low_o |-> $past(ghg) && $past(plg) && $past(prio_on))
        else $error("low request without both gates");
    AST_HIGH_REQ: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !prio_on && ghg && pend[2] |=> irq_high_o)
        else $error("request missing");
    AST_PRIO_HI: assert property (@(posedge clk_i) disable iff (!resetn_i)
        prio_on && ghg && ((pend & is_hi) != 3'h0) |=> irq_high_o)
        else $error("high priority request missing");
endmodule
`default_nettype wire

// ==== include/igf_consts.svh ====
`ifndef IGF_CONSTS_SVH
`define IGF_CONSTS_SVH
// Register byte offsets
`define IGF_OFF_GATEFLAGS   32'h0000_0000
`define IGF_OFF_PRIOCTL     32'h0000_0004
`define IGF_OFF_STATUS      32'h0000_0008
// Field positions in the gate and flag register
`define IGF_BIT_GHG         7
`define IGF_BIT_PLG         6
`define IGF_BIT_T0E         5
`define IGF_BIT_E0E         4
`define IGF_BIT_PBE         3
`define IGF_BIT_T0F         2
`define IGF_BIT_E0F         1
`define IGF_BIT_PBF         0
// Field positions in the priority control register
`define IGF_BIT_PRIO_ON     0
`define IGF_BIT_T0_HI       1
`define IGF_BIT_E0_HI       2
`define IGF_BIT_PB_HI       3
// Reset values
`define IGF_RST_GATEFLAGS   8'h00
`define IGF_RST_PRIOCTL     4'h0
// AXI responses
`define IGF_RESP_OKAY       2'h0
`define IGF_RESP_SLVERR     2'h2
// Latch keeps following the pins one more instruction cycle after a port read
`define IGF_INSTR_CYCLES    2'h1
`endif

// ==== include/igf_pkg.sv ====
package igf_pkg;
    typedef logic [7:0] igf_reg_t;
    typedef enum logic [1:0] {IGF_WR_IDLE, IGF_WR_RESP} igf_wr_e;
    typedef enum logic [1:0] {IGF_RD_IDLE, IGF_RD_RESP} igf_rd_e;
endpackage

// ==== tb/igf_src_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module igf_src_model
    import igf_pkg::*;
(
    input  wire logic       clk_i,            // System clock
    input  wire logic       tmr_req_i,        // Bench asks for a timer overflow
    input  wire logic       ext_req_i,        // Bench asks for a pin 0 event
    input  wire logic [3:0] pins_req_i,       // Level wanted on port pins 7..4
    input  wire logic       rd_req_i,         // Bench asks for a port read
    output logic            timer_zero_ovf_o, // One-cycle overflow pulse
    output logic            ext_pin_zero_o,   // One-cycle pin event pulse
    output logic [3:0]      pins_o,           // Port pins 7..4
    output logic            port_read_o       // One-cycle port read strobe
);
    ////////////////////////////////////////////////////////////////
    // Registered so every event is a clean one-cycle pulse off the edge
    always_ff @(posedge clk_i)
    begin
        timer_zero_ovf_o <= tmr_req_i;
        ext_pin_zero_o   <= ext_req_i;
        pins_o           <= pins_req_i;
        port_read_o      <= rd_req_i;
    end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "igf_consts.svh"
module tb
    import igf_pkg::*;
;
    localparam logic [31:0] A_GF = `IGF_OFF_GATEFLAGS;
    localparam logic [31:0] A_PC = `IGF_OFF_PRIOCTL;
    localparam logic [31:0] A_ST = `IGF_OFF_STATUS;
    logic clk_i, resetn_i, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq_h, irq_l, tov, e0, prd;
    logic tmr_req, ext_req, rd_req;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [1:0]  bresp, rresp, resp;
    logic [3:0]  pins, pins_req;
    logic [31:0] rv;
    int n_errors, n_tests, cyc;
    igf_top DUT (.clk_i(clk_i), .resetn_i(resetn_i),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .timer_zero_ovf_i(tov), .ext_pin_zero_i(e0), .second_io_port_i(pins),
        .port_read_i(prd), .irq_high_o(irq_h), .irq_low_o(irq_l));
    igf_src_model u_src (.clk_i(clk_i), .tmr_req_i(tmr_req), .ext_req_i(ext_req),
        .pins_req_i(pins_req), .rd_req_i(rd_req), .timer_zero_ovf_o(tov),
        .ext_pin_zero_o(e0), .pins_o(pins), .port_read_o(prd));
    ////////////////////////////////////////////////////////////////
    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Far above the few hundred cycles the sequence needs
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_errors++;
            wrap_up();
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            n_errors++;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    // Handshakes are judged at the rising edge that takes them
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic bh;
        @(posedge clk_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        bh = 1'b0;
        while (!bh)
        begin
            @(posedge clk_i);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready)
            begin
                bh = 1'b1;
                resp = bresp;
                bready <= 1'b0;
            end
        end
    endtask
    task automatic rd(input logic [31:0] a);
        logic rh;
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        rh = 1'b0;
        while (!rh)
        begin
            @(posedge clk_i);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready)
            begin
                rh = 1'b1;
                rv = rdata;
                resp = rresp;
                rready <= 1'b0;
            end
        end
    endtask
    task automatic ckr(input string nm, input logic [31:0] a, input logic [31:0] exp);
        rd(a);
        chk(nm, exp, rv);
    endtask
    task automatic ck_irq(input logic h, input logic l);
        repeat (3) @(posedge clk_i);
        chk("irq_high", {31'h0, h}, {31'h0, irq_h});
        chk("irq_low", {31'h0, l}, {31'h0, irq_l});
    endtask
    // Source 0 timer, 1 pin 0, 2 port change; the port is read to end the mismatch
    task automatic fire(input int s);
        @(posedge clk_i);
        tmr_req <= (s == 0);
        ext_req <= (s == 1);
        if (s == 2) pins_req <= ~pins_req;
        @(posedge clk_i);
        tmr_req <= 1'b0;
        ext_req <= 1'b0;
        if (s == 2)
        begin
            repeat (2) @(posedge clk_i);
            rd_req <= 1'b1;
            @(posedge clk_i);
            rd_req <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        {resetn_i, awvalid, wvalid, bready, arvalid, rready, tmr_req, ext_req, rd_req} = '0;
        {awaddr, wdata, araddr, pins_req} = '0;
        n_errors = 0;
        n_tests = 0;
        cyc = 0;
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
        ckr("gate_flags", A_GF, {24'h0, `IGF_RST_GATEFLAGS});
        ckr("prio_ctl", A_PC, {28'h0, `IGF_RST_PRIOCTL});
        ckr("status", A_ST, 32'h0);
        ckr("unmapped", 32'h0000_0010, 32'h0);
        chk("rresp", {30'h0, `IGF_RESP_SLVERR}, {30'h0, resp});
        wr(32'h0000_0010, 32'hFF);
        chk("bresp", {30'h0, `IGF_RESP_SLVERR}, {30'h0, resp});
        fire(0);
        ckr("timer_flag", A_GF, 32'h04);
        wr(A_GF, 32'h04);
        ckr("flag_kept", A_GF, 32'h04);
        wr(A_GF, 32'h00);
        ckr("flag_cleared", A_GF, 32'h00);
        fire(1);
        ckr("ext_flag", A_GF, 32'h02);
        wr(A_GF, 32'h00);
        @(posedge clk_i);
        pins_req <= 4'h8;
        repeat (3) @(posedge clk_i);
        ckr("port_flag", A_GF, 32'h01);
        ckr("mismatch", A_ST, 32'h04);
        wr(A_GF, 32'h00);
        ckr("flag_resets", A_GF, 32'h01);
        fire(2);
        repeat (4) @(posedge clk_i);
        wr(A_GF, 32'h00);
        ckr("flag_clears", A_GF, 32'h00);
        for (int s = 0; s < 3; s++)
        begin
            wr(A_GF, 32'h00);
            wr(A_GF, 32'h80 | (32'h20 >> s));
            ck_irq(1'b0, 1'b0);
            fire(s);
            ck_irq(1'b1, 1'b0);
            wr(A_GF, (32'h20 >> s) | (32'h04 >> s));
            ck_irq(1'b0, 1'b0);
            wr(A_GF, 32'h80 | (32'h04 >> s));
            ck_irq(1'b0, 1'b0);
        end
        wr(A_GF, 32'hA4);
        fire(0);
        ck_irq(1'b1, 1'b0);
        ckr("status_irq", A_ST, 32'h01);
        wr(A_PC, 32'h1);
        ckr("prio_ctl", A_PC, 32'h1);
        wr(A_GF, 32'hA4);
        ck_irq(1'b0, 1'b0);
        wr(A_GF, 32'hE4);
        ck_irq(1'b0, 1'b1);
        wr(A_GF, 32'h64);
        ck_irq(1'b0, 1'b0);
        wr(A_PC, 32'h3);
        wr(A_GF, 32'hA4);
        ck_irq(1'b1, 1'b0);
        wr(A_GF, 32'h24);
        ck_irq(1'b0, 1'b0);
        wrap_up();
    end
endmodule
`default_nettype wire
